/* File: amwe_ctrl.sv */
// Wait handling, bus parking and event logic of the external memory controller
`timescale 1ns/1ps
`include "amwe_params.svh"

// Summary of operation
// - NAND status register shows the current synchronised wait pin level.
// - Every rising edge of the wait pin sets the wait-rise raw event.
// - Wait polarity does not touch the NAND status or wait-rise event.
// - With extended wait enabled, the wait pin is watched during the strobe.
// - Active wait inserts strobe cycles; release resumes at the last strobe cycle.
// - Extension stops at the maximum wait count; then hold starts anyway.
// - Wait still active when the maximum count expires sets the timeout event.
// - Polarity resets to 1; 1 waits on high, 0 waits on low.
// - Idle data bus is driven with the last written value.
// - Bus released only during reads; parking resumes right after the capture.
// - Either reset drops any access and restores all defaults.
// - One interrupt output, raised only by wait-rise and timeout events.
// - Writing 1 to enable-set enables, to enable-clear disables; 0 does nothing.
// - Enable-set and enable-clear both read back the current enable bits.
// - Raw bits always set; masked bits set only when the event is enabled.
// - Writing 1 to a raw bit clears it and its masked bit.
module amwe_ctrl (
  // Clock and resets
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        PWR_RST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // External memory pins
  input  wire logic        EXT_WAIT_PIN,
  input  wire logic [7:0]  MEM_DATA_I,
  output logic      [7:0]  MEM_DATA_O,
  output logic             MEM_DATA_OE,
  output logic      [3:0]  MEM_CS_N,
  output logic             MEM_OE_N,
  output logic             MEM_WE_N,
  // Interrupt
  output logic             EVT_IRQ
);

  amwe_pkg::amwe_state_s s_r;
  amwe_pkg::amwe_state_s s_nxt;

  logic        any_rst;
  logic        bus_req;
  logic        wr_hit;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] cur_cfg;
  logic [5:0]  su_len;
  logic [5:0]  stb_len;
  logic        wait_act;
  logic        wait_rise;
  logic        ext_on;
  logic        ev_timeout;
  logic [31:0] rdata;

  // Both resets act the same way on every flop
  assign any_rst = RST | PWR_RST;

  // Byte lanes from the select lines
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
    end
  end

  assign bus_req = WB_CYC_I & WB_STB_I & ~s_r.ack;
  assign wr_hit  = bus_req & WB_WE_I;
  assign wval    = WB_DAT_I & wmask;

  // Timing of the chip select in use
  always_comb begin
    unique case (s_r.cs_sel)
      2'd0: cur_cfg = s_r.cs_cfg0;
      2'd1: cur_cfg = s_r.cs_cfg1;
      2'd2: cur_cfg = s_r.cs_cfg2;
      default: cur_cfg = s_r.cs_cfg3;
    endcase
  end

  // Field counts are stored minus one
  always_comb begin
    if (s_r.is_read) begin
      su_len  = {2'b00, cur_cfg[`AMWE_CS_RSU_LSB +: 4]} + 6'd1;
      stb_len = cur_cfg[`AMWE_CS_RSTB_LSB +: 6] + 6'd1;
    end else begin
      su_len  = {2'b00, cur_cfg[`AMWE_CS_WSU_LSB +: 4]} + 6'd1;
      stb_len = cur_cfg[`AMWE_CS_WSTB_LSB +: 6] + 6'd1;
    end
  end

  // Only the second synchroniser stage feeds logic
  assign wait_rise = s_r.wait_sync[1] & ~s_r.wait_lvl;
  // Polarity applies only to strobe stretching and the timeout event
  assign wait_act  = s_r.wait_polarity ? s_r.wait_sync[1] : ~s_r.wait_sync[1];
  assign ext_on    = cur_cfg[`AMWE_CS_EW_BIT];

  // Timeout when the stretch budget is used up with wait still active
  assign ev_timeout = (s_r.phase == amwe_pkg::AMWE_STROBE) & s_r.extending & wait_act
                    & (s_r.ext_cnt >= s_r.max_wait_count);

  // Register read mux
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (WB_ADR_I)
      `AMWE_OFF_WAIT_CFG: begin
        rdata[`AMWE_WCFG_MAX_WAIT_COUNT_LSB +: 8] = s_r.max_wait_count;
        rdata[`AMWE_WCFG_POL_BIT]       = s_r.wait_polarity;
      end
      `AMWE_OFF_CS0_CFG: rdata = s_r.cs_cfg0;
      `AMWE_OFF_CS1_CFG: rdata = s_r.cs_cfg1;
      `AMWE_OFF_CS2_CFG: rdata = s_r.cs_cfg2;
      `AMWE_OFF_CS3_CFG: rdata = s_r.cs_cfg3;
      `AMWE_OFF_EVT_RAW: begin
        rdata[`AMWE_EVT_TIMEOUT_BIT] = s_r.timeout_raw;
        rdata[`AMWE_EVT_WRISE_BIT]   = s_r.wait_rise_raw;
      end
      `AMWE_OFF_EVT_MASKED: begin
        rdata[`AMWE_EVT_TIMEOUT_BIT] = s_r.timeout_masked;
        rdata[`AMWE_EVT_WRISE_BIT]   = s_r.wait_rise_masked;
      end
      `AMWE_OFF_EVT_EN_SET, `AMWE_OFF_EVT_EN_CLR: begin
        rdata[`AMWE_EVT_TIMEOUT_BIT] = s_r.timeout_en;
        rdata[`AMWE_EVT_WRISE_BIT]   = s_r.wait_rise_en;
      end
      `AMWE_OFF_NAND_STATUS: rdata[0] = s_r.wait_lvl;
      `AMWE_OFF_ACC_STATUS: begin
        rdata[0]     = (s_r.phase != amwe_pkg::AMWE_IDLE);
        rdata[8 +: 8] = s_r.read_data;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Next state
  always_comb begin
    s_nxt = s_r;
    // Pin synchroniser and registered level
    s_nxt.wait_sync = {s_r.wait_sync[0], EXT_WAIT_PIN};
    s_nxt.wait_lvl  = s_r.wait_sync[1];
    s_nxt.ack       = bus_req;
    s_nxt.dat_o     = bus_req ? rdata : 32'h0000_0000;

    // Register writes
    if (wr_hit) begin
      unique case (WB_ADR_I)
        `AMWE_OFF_WAIT_CFG: begin
          if (WB_SEL_I[0]) s_nxt.max_wait_count = WB_DAT_I[`AMWE_WCFG_MAX_WAIT_COUNT_LSB +: 8];
          if (WB_SEL_I[3]) s_nxt.wait_polarity  = WB_DAT_I[`AMWE_WCFG_POL_BIT];
        end
        `AMWE_OFF_CS0_CFG: s_nxt.cs_cfg0 = (s_r.cs_cfg0 & ~wmask) | wval;
        `AMWE_OFF_CS1_CFG: s_nxt.cs_cfg1 = (s_r.cs_cfg1 & ~wmask) | wval;
        `AMWE_OFF_CS2_CFG: s_nxt.cs_cfg2 = (s_r.cs_cfg2 & ~wmask) | wval;
        `AMWE_OFF_CS3_CFG: s_nxt.cs_cfg3 = (s_r.cs_cfg3 & ~wmask) | wval;
        `AMWE_OFF_EVT_RAW: begin
          // Clear raw and masked together
          if (wval[`AMWE_EVT_TIMEOUT_BIT]) begin
            s_nxt.timeout_raw    = 1'b0;
            s_nxt.timeout_masked = 1'b0;
          end
          if (wval[`AMWE_EVT_WRISE_BIT]) begin
            s_nxt.wait_rise_raw    = 1'b0;
            s_nxt.wait_rise_masked = 1'b0;
          end
        end
        `AMWE_OFF_EVT_EN_SET: begin
          if (wval[`AMWE_EVT_TIMEOUT_BIT]) s_nxt.timeout_en = 1'b1;
          if (wval[`AMWE_EVT_WRISE_BIT])   s_nxt.wait_rise_en = 1'b1;
        end
        `AMWE_OFF_EVT_EN_CLR: begin
          if (wval[`AMWE_EVT_TIMEOUT_BIT]) s_nxt.timeout_en = 1'b0;
          if (wval[`AMWE_EVT_WRISE_BIT])   s_nxt.wait_rise_en = 1'b0;
        end
        `AMWE_OFF_ACC_CTRL: begin
          // Start an access only from idle; otherwise ignored
          if (WB_DAT_I[`AMWE_ACC_START_BIT] && s_r.phase == amwe_pkg::AMWE_IDLE) begin
            s_nxt.phase   = amwe_pkg::AMWE_SETUP;
            s_nxt.is_read = WB_DAT_I[`AMWE_ACC_READ_BIT];
            s_nxt.cs_sel  = WB_DAT_I[`AMWE_ACC_CS_LSB +: 2];
            s_nxt.cnt     = 6'd0;
            s_nxt.ext_cnt = 8'd0;
            s_nxt.extending = 1'b0;
            if (!WB_DAT_I[`AMWE_ACC_READ_BIT])
              s_nxt.park_data = WB_DAT_I[`AMWE_ACC_DATA_LSB +: 8];
          end
        end
        default: ;
      endcase
    end

    // Events set after any clear so a simultaneous set wins
    if (wait_rise) begin
      s_nxt.wait_rise_raw = 1'b1;
      if (s_r.wait_rise_en) s_nxt.wait_rise_masked = 1'b1;
    end
    if (ev_timeout) begin
      s_nxt.timeout_raw = 1'b1;
      if (s_r.timeout_en) s_nxt.timeout_masked = 1'b1;
    end

    // Access sequencer
    unique case (s_r.phase)
      amwe_pkg::AMWE_IDLE: ;
      amwe_pkg::AMWE_SETUP: begin
        if (s_r.cnt + 6'd1 >= su_len) begin
          s_nxt.phase = amwe_pkg::AMWE_STROBE;
          s_nxt.cnt   = 6'd0;
        end else begin
          s_nxt.cnt = s_r.cnt + 6'd1;
        end
      end
      amwe_pkg::AMWE_STROBE: begin
        if (s_r.extending) begin
          // Stretch until release or budget spent
          if (!wait_act) begin
            s_nxt.extending = 1'b0;
          end else if (s_r.ext_cnt >= s_r.max_wait_count) begin
            s_nxt.phase = amwe_pkg::AMWE_HOLD;
            s_nxt.cnt   = 6'd0;
            s_nxt.extending = 1'b0;
            // A cut strobe still ends the read with a capture
            if (s_r.is_read) s_nxt.read_data = MEM_DATA_I;
          end else begin
            s_nxt.ext_cnt = s_r.ext_cnt + 8'd1;
          end
        end else if (s_r.cnt + 6'd1 >= stb_len) begin
          // Last programmed strobe cycle
          if (ext_on && wait_act && s_r.ext_cnt == 8'd0) begin
            s_nxt.extending = 1'b1;
          end else begin
            s_nxt.phase = amwe_pkg::AMWE_HOLD;
            s_nxt.cnt   = 6'd0;
            if (s_r.is_read) s_nxt.read_data = MEM_DATA_I;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 6'd1;
        end
      end
      amwe_pkg::AMWE_HOLD: begin
        s_nxt.phase = amwe_pkg::AMWE_IDLE;
      end
      default: s_nxt.phase = amwe_pkg::AMWE_IDLE;
    endcase

    // Pin outputs follow the next phase
    s_nxt.cs_n = 4'hF;
    s_nxt.oe_n = 1'b1;
    s_nxt.we_n = 1'b1;
    if (s_nxt.phase != amwe_pkg::AMWE_IDLE) s_nxt.cs_n[s_nxt.cs_sel] = 1'b0;
    if (s_nxt.phase == amwe_pkg::AMWE_STROBE) begin
      s_nxt.oe_n = ~s_nxt.is_read;
      s_nxt.we_n = s_nxt.is_read;
    end
    // Bus floats only in setup and strobe of a read; parked otherwise
    s_nxt.data_oe = !(s_nxt.is_read && (s_nxt.phase == amwe_pkg::AMWE_SETUP
                    || s_nxt.phase == amwe_pkg::AMWE_STROBE));

    s_nxt.irq = s_nxt.wait_rise_masked | s_nxt.timeout_masked;
  end

  // State register; both resets abandon any access at once
  always_ff @(posedge SYS_CLK) begin
    if (any_rst) begin
      s_r                <= '0;
      // Synchroniser resets to the high level, so a pin high at reset is no false rise
      s_r.wait_sync      <= 2'b11;
      s_r.wait_lvl       <= 1'b1;
      s_r.max_wait_count <= 8'(`AMWE_WCFG_RESET);
      s_r.wait_polarity  <= 1'b1;
      s_r.cs_cfg0        <= `AMWE_CS_RESET;
      s_r.cs_cfg1        <= `AMWE_CS_RESET;
      s_r.cs_cfg2        <= `AMWE_CS_RESET;
      s_r.cs_cfg3        <= `AMWE_CS_RESET;
      s_r.phase          <= amwe_pkg::AMWE_IDLE;
      s_r.cs_n           <= 4'hF;
      s_r.oe_n           <= 1'b1;
      s_r.we_n           <= 1'b1;
      s_r.data_oe        <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign WB_DAT_O    = s_r.dat_o;
  assign WB_ACK_O    = s_r.ack;
  assign MEM_DATA_O  = s_r.park_data;
  assign MEM_DATA_OE = s_r.data_oe;
  assign MEM_CS_N    = s_r.cs_n;
  assign MEM_OE_N    = s_r.oe_n;
  assign MEM_WE_N    = s_r.we_n;
  assign EVT_IRQ     = s_r.irq;

endmodule : amwe_ctrl

/* File: amwe_ctrl_properties.sv */
// Port-level checks of the wait and event block
`timescale 1ns/1ps
module amwe_ctrl_properties (
  // Clock and resets
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        PWR_RST,
  // Bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Memory side and interrupt
  input wire logic        MEM_DATA_OE,
  input wire logic [3:0]  MEM_CS_N,
  input wire logic        MEM_OE_N,
  input wire logic        MEM_WE_N,
  input wire logic        EVT_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST || PWR_RST);
  logic [9:0] stb_len_r;
  // Strobe run length, so a stuck wait pin cannot hide
  always_ff @(posedge SYS_CLK) begin
    if (RST || PWR_RST || (MEM_OE_N && MEM_WE_N)) stb_len_r <= 10'h000;
    else if (stb_len_r != 10'h3FF) stb_len_r <= stb_len_r + 10'h001;
  end
  sequence s_wb_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_once;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  chk_ack_one_cycle: assert property (s_wb_req |=> s_ack_once) else $error("ack timing");
  chk_dat_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
    else $error("read data outside ack");
  chk_park_idle_bus: assert property ((MEM_CS_N == 4'hF) |-> MEM_DATA_OE)
    else $error("idle bus not driven");
  chk_release_read_only: assert property (!MEM_DATA_OE |-> MEM_WE_N && MEM_CS_N != 4'hF)
    else $error("bus released outside read");
  chk_repark_after_read: assert property ($rose(MEM_OE_N) |-> ##[0:1] MEM_DATA_OE)
    else $error("bus not parked after read");
  chk_strobe_cap_bound: assert property (stb_len_r <= 10'h14A)
    else $error("strobe not capped");
  chk_strobe_excl_dir: assert property (!(!MEM_OE_N && !MEM_WE_N)) else $error("both strobes");
  chk_reset_idle_pins: assert property (disable iff (1'b0)
    ($past(RST) || $past(PWR_RST)) |-> MEM_CS_N == 4'hF && MEM_OE_N && MEM_WE_N
    && MEM_DATA_OE && !WB_ACK_O && !EVT_IRQ) else $error("reset did not idle pins");
endmodule : amwe_ctrl_properties

bind amwe_ctrl amwe_ctrl_properties chk_u (.SYS_CLK(SYS_CLK), .RST(RST), .PWR_RST(PWR_RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .MEM_DATA_OE(MEM_DATA_OE), .MEM_CS_N(MEM_CS_N), .MEM_OE_N(MEM_OE_N),
  .MEM_WE_N(MEM_WE_N), .EVT_IRQ(EVT_IRQ));

/* File: amwe_ctrl_tb.sv */
// Self-checking bench for the wait and event block
`timescale 1ns/1ps
`include "amwe_params.svh"
module amwe_ctrl_tb;
  logic        clk, rst, pwr_rst, cyc, stb, we, ack, oe, oe_n, we_n, irq, wpin;
  logic        use_pin, pin_lvl, busy_lvl;
  logic [7:0]  adr, busy_len, mdi, mdo;
  logic [3:0]  cs_n;
  logic [31:0] wdat, rdat, q;
  int          fail_count, checked, oe_cnt;

  amwe_ctrl dut_u (.SYS_CLK(clk), .RST(rst), .PWR_RST(pwr_rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .EXT_WAIT_PIN(wpin), .MEM_DATA_I(mdi),
    .MEM_DATA_O(mdo), .MEM_DATA_OE(oe), .MEM_CS_N(cs_n), .MEM_OE_N(oe_n),
    .MEM_WE_N(we_n), .EVT_IRQ(irq));
  amwe_mem_model mem_u (.clk(clk), .oe_n(oe_n), .we_n(we_n), .use_pin(use_pin),
    .pin_lvl(pin_lvl), .busy_lvl(busy_lvl), .busy_len(busy_len), .wait_pin(wpin),
    .data_o(mdi));

  // Free-running clock and read-strobe cycle count
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (oe_n === 1'b0) oe_cnt++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // Start an access and poll busy under a bound
  task automatic acc(input logic [31:0] ctl);
    int i;
    oe_cnt = 0;
    wb(1'b1, `AMWE_OFF_ACC_CTRL, ctl);
    for (i = 0; i < 100; i++) begin
      rd(`AMWE_OFF_ACC_STATUS);
      if (q[0] === 1'b0) break;
    end
  endtask : acc
  // Low then high on the pin; settles past the synchroniser
  task automatic pulse;
    pin_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    pin_lvl <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : pulse

  task automatic t_reset;
    rd(`AMWE_OFF_WAIT_CFG);
    chk(q, `AMWE_WCFG_RESET);
    rd(`AMWE_OFF_EVT_RAW);
    chk(q, 32'h0000_0000);
    rd(`AMWE_OFF_EVT_EN_CLR);
    chk(q, 32'h0000_0000);
    rd(8'h30);
    chk(q, 32'h0000_0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_status;
    pin_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`AMWE_OFF_NAND_STATUS);
    chk({31'h0000_0000, q[0]}, 32'h0000_0001);
    rd(`AMWE_OFF_EVT_RAW);
    chk(q, 32'h0000_0004);
    wb(1'b1, `AMWE_OFF_WAIT_CFG, 32'h0000_0080);
    wb(1'b1, `AMWE_OFF_EVT_RAW, 32'h0000_0004);
    pulse;
    rd(`AMWE_OFF_EVT_RAW);
    chk(q, 32'h0000_0004);
    rd(`AMWE_OFF_NAND_STATUS);
    chk({31'h0000_0000, q[0]}, 32'h0000_0001);
    $display("t_status done");
  endtask : t_status
  task automatic t_events;
    wb(1'b1, `AMWE_OFF_EVT_RAW, 32'h0000_0005);
    wb(1'b1, `AMWE_OFF_EVT_EN_SET, 32'h0000_0004);
    wb(1'b1, `AMWE_OFF_EVT_EN_SET, 32'h0000_0000);
    wb(1'b1, `AMWE_OFF_EVT_EN_CLR, 32'h0000_0000);
    rd(`AMWE_OFF_EVT_EN_SET);
    chk(q, 32'h0000_0004);
    rd(`AMWE_OFF_EVT_EN_CLR);
    chk(q, 32'h0000_0004);
    pulse;
    rd(`AMWE_OFF_EVT_MASKED);
    chk(q, 32'h0000_0004);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wb(1'b1, `AMWE_OFF_EVT_RAW, 32'h0000_0004);
    rd(`AMWE_OFF_EVT_RAW);
    chk(q, 32'h0000_0000);
    rd(`AMWE_OFF_EVT_MASKED);
    chk(q, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wb(1'b1, `AMWE_OFF_EVT_EN_CLR, 32'h0000_0004);
    pulse;
    rd(`AMWE_OFF_EVT_MASKED);
    chk(q, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("t_events done");
  endtask : t_events
  task automatic t_access;
    // Model drives a ready pin, so the first write is not stretched into a timeout
    use_pin <= 1'b0;
    wb(1'b1, `AMWE_OFF_WAIT_CFG, 32'h1000_0008);
    wb(1'b1, `AMWE_OFF_CS0_CFG, 32'h4002_0C83);
    wb(1'b1, `AMWE_OFF_EVT_RAW, 32'h0000_0005);
    wb(1'b1, `AMWE_OFF_EVT_EN_SET, 32'h0000_0001);
    acc(32'h0000_A501);
    chk({24'h00_0000, mdo}, 32'h0000_00A5);
    busy_len <= 8'h04;
    acc(32'h0000_0003);
    chk({24'h00_0000, mdo}, 32'h0000_00A5);
    chk({31'h0000_0000, q[15:8] === 8'h3C}, 32'h0000_0001);
    chk({31'h0000_0000, oe_cnt > 4 && oe_cnt < 11}, 32'h0000_0001);
    rd(`AMWE_OFF_EVT_RAW);
    chk({31'h0000_0000, q[0]}, 32'h0000_0000);
    busy_len <= 8'hFF;
    acc(32'h0000_0003);
    chk({31'h0000_0000, oe_cnt > 10 && oe_cnt < 14}, 32'h0000_0001);
    rd(`AMWE_OFF_EVT_RAW);
    chk({31'h0000_0000, q[0]}, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wb(1'b1, `AMWE_OFF_EVT_RAW, 32'h0000_0005);
    // Extended wait off, then polarity 0: a busy-high pin must not stretch the strobe
    wb(1'b1, `AMWE_OFF_CS0_CFG, 32'h0002_0C83);
    acc(32'h0000_0003);
    chk({31'h0000_0000, oe_cnt < 6}, 32'h0000_0001);
    wb(1'b1, `AMWE_OFF_CS0_CFG, 32'h4002_0C83);
    wb(1'b1, `AMWE_OFF_WAIT_CFG, 32'h0000_0008);
    acc(32'h0000_0003);
    chk({31'h0000_0000, oe_cnt < 6}, 32'h0000_0001);
    $display("t_access done");
  endtask : t_access
  // Power reset in mid-strobe abandons the access
  task automatic t_pwr_reset;
    wb(1'b1, `AMWE_OFF_WAIT_CFG, 32'h1000_0080);
    wb(1'b1, `AMWE_OFF_ACC_CTRL, 32'h0000_0003);
    repeat (8) @(posedge clk);
    chk({28'h000_0000, cs_n}, 32'h0000_000E);
    pwr_rst <= 1'b1;
    @(posedge clk);
    pwr_rst <= 1'b0;
    @(posedge clk);
    chk({28'h000_0000, cs_n}, 32'h0000_000F);
    rd(`AMWE_OFF_EVT_EN_SET);
    chk(q, 32'h0000_0000);
    rd(`AMWE_OFF_CS0_CFG);
    chk(q, `AMWE_CS_RESET);
    $display("t_pwr_reset done");
  endtask : t_pwr_reset

  task automatic print_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    {rst, pwr_rst, cyc, stb, we, use_pin, pin_lvl, busy_lvl} = 8'h85;
    {adr, wdat, busy_len} = 48'h0000_0000_0000;
    fail_count = 0;
    checked = 0;
    oe_cnt = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_status;
    t_events;
    t_access;
    t_pwr_reset;
    print_verdict;
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
endmodule : amwe_ctrl_tb

/* File: amwe_mem_model.sv */
// Behavioural memory with a ready/busy output on the wait pin
`timescale 1ns/1ps
module amwe_mem_model (
  // Clock and controller strobes
  input  wire logic       clk,
  input  wire logic       oe_n,
  input  wire logic       we_n,
  // Scenario control
  input  wire logic       use_pin,
  input  wire logic       pin_lvl,
  input  wire logic       busy_lvl,
  input  wire logic [7:0] busy_len,
  // Pins to the controller
  output logic            wait_pin,
  output logic [7:0]      data_o
);
  logic [7:0] cnt_r;
  logic [7:0] last_r;
  logic       strb_r;
  // Busy window opens as a strobe begins; 8'hFF never closes
  always_ff @(posedge clk) begin
    strb_r <= !(oe_n && we_n);
    if (use_pin) cnt_r <= 8'h00;
    else if (!(oe_n && we_n) && !strb_r) cnt_r <= busy_len;
    else if (cnt_r != 8'h00 && cnt_r != 8'hFF) cnt_r <= cnt_r - 8'h01;
    if (use_pin || !oe_n) last_r <= 8'h3C;
  end
  assign wait_pin = use_pin ? pin_lvl : ((cnt_r != 8'h00) ? busy_lvl : !busy_lvl);
  // Undriven bus shows the inverse of the last value, never a held copy
  assign data_o = !oe_n ? 8'h3C : ~last_r;
endmodule : amwe_mem_model

/* File: amwe_params.svh */
// Register offsets, field positions, reset values and timing counts of the wait and event block
`ifndef AMWE_PARAMS_SVH
`define AMWE_PARAMS_SVH

// Register byte offsets
`define AMWE_OFF_WAIT_CFG      8'h00
`define AMWE_OFF_CS0_CFG       8'h04
`define AMWE_OFF_CS1_CFG       8'h08
`define AMWE_OFF_CS2_CFG       8'h0C
`define AMWE_OFF_CS3_CFG       8'h10
`define AMWE_OFF_EVT_RAW       8'h14
`define AMWE_OFF_EVT_MASKED    8'h18
`define AMWE_OFF_EVT_EN_SET    8'h1C
`define AMWE_OFF_EVT_EN_CLR    8'h20
`define AMWE_OFF_NAND_STATUS   8'h24
`define AMWE_OFF_ACC_CTRL      8'h28
`define AMWE_OFF_ACC_STATUS    8'h2C

// Wait configuration fields
`define AMWE_WCFG_MAX_WAIT_COUNT_LSB     0
`define AMWE_WCFG_POL_BIT      28
`define AMWE_WCFG_RESET        32'h1000_0080

// Chip select timing fields
`define AMWE_CS_RSTB_LSB       0
`define AMWE_CS_RSU_LSB        6
`define AMWE_CS_WSTB_LSB       10
`define AMWE_CS_WSU_LSB        16
`define AMWE_CS_EW_BIT         30
`define AMWE_CS_RESET          32'h0000_0000

// Event bit positions
`define AMWE_EVT_TIMEOUT_BIT   0
`define AMWE_EVT_WRISE_BIT     2

// Access control fields
`define AMWE_ACC_START_BIT     0
`define AMWE_ACC_READ_BIT      1
`define AMWE_ACC_CS_LSB        2
`define AMWE_ACC_DATA_LSB      8

// Least setup plus strobe sum for wait recognition
`define AMWE_MIN_SU_STB        5'h04

`endif

/* File: amwe_pkg.sv */
// Types of the wait and event block
package amwe_pkg;

  // Access sequencer phases, one-hot
  typedef enum logic [3:0] {
    AMWE_IDLE   = 4'b0001,
    AMWE_SETUP  = 4'b0010,
    AMWE_STROBE = 4'b0100,
    AMWE_HOLD   = 4'b1000
  } amwe_phase_e;

  // Whole state of the block
  typedef struct packed {
    logic [1:0]  wait_sync;
    logic        wait_lvl;
    logic [7:0]  max_wait_count;
    logic        wait_polarity;
    logic [31:0] cs_cfg0;
    logic [31:0] cs_cfg1;
    logic [31:0] cs_cfg2;
    logic [31:0] cs_cfg3;
    logic        wait_rise_raw;
    logic        timeout_raw;
    logic        wait_rise_masked;
    logic        timeout_masked;
    logic        wait_rise_en;
    logic        timeout_en;
    amwe_phase_e phase;
    logic        is_read;
    logic [1:0]  cs_sel;
    logic [5:0]  cnt;
    logic [7:0]  ext_cnt;
    logic        extending;
    logic [7:0]  park_data;
    logic [7:0]  read_data;
    logic        data_oe;
    logic [3:0]  cs_n;
    logic        oe_n;
    logic        we_n;
    logic        irq;
    logic        ack;
    logic [31:0] dat_o;
  } amwe_state_s;

endpackage : amwe_pkg
